// File: dv/optical_rx_model.sv
// Behavioural optical receiver: serial bits with bounded runs, plus signal detect.
// Assumes the bench pulses run_go for one clk_sys cycle to request a run of run_len bits.
`timescale 1ns/1ps
module optical_rx_model (
  input  wire logic       clk_sys,
  input  wire logic       power_ok,
  input  wire logic       run_go,
  input  wire logic [8:0] run_len,
  output logic            rx_serial_data,
  output logic            signal_detect_in
);
  logic [8:0] run_left;
  logic [2:0] same_cnt;

  initial begin
    rx_serial_data = 1'b0;
    run_left       = 9'h000;
    same_cnt       = 3'h0;
  end

  assign signal_detect_in = power_ok;

  ////////////////////////////////////////////////////////////////////////////////
  // Random data never repeats more than four bits, so only a requested run is long
  always @(posedge clk_sys) begin
    if (run_go) begin
      run_left       <= run_len - 9'd1;
      rx_serial_data <= ~rx_serial_data;
    end else if (run_left != 9'd0) begin
      run_left <= run_left - 9'd1;
      // Forces a transition right after the run, so its length is exact
      same_cnt <= 3'd3;
    end else if (same_cnt == 3'd3 || $urandom_range(1) == 1) begin
      rx_serial_data <= ~rx_serial_data;
      same_cnt       <= 3'd0;
    end else begin
      same_cnt <= same_cnt + 3'd1;
    end
  end
endmodule : optical_rx_model

// File: dv/rx_line_lock_monitor_tb_top.sv
// Self-checking bench for the receive line monitor, APB master and read scoreboard.
// Assumes an APB slave that answers in time and one serial bit per clk_sys edge.
`timescale 1ns/1ps
`include "rx_line_cfg.svh"
module rx_line_lock_monitor_tb_top;
  typedef struct packed {
    logic        err;
    logic [31:0] msk;
    logic [31:0] dat;
  } note_s;

  localparam logic [11:0] A_CFG = 12'(`RXL_IDX_CONFIG * 4);
  localparam logic [11:0] A_STS = 12'(`RXL_IDX_STATUS * 4);
  localparam logic [11:0] A_REC = 12'(`RXL_IDX_RECOVERY * 4);
  localparam logic [11:0] A_BAD = A_REC + 12'h004;

  logic        clk_sys, resetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic [3:0]  pstrb;
  logic        rx_serial_data, signal_detect_in, line_iface_select, par_frame_pulse_in;
  logic        data_freq_unlock, ref_unlock_in, lock_to_data_in, power_ok, run_go;
  logic        recovery_mode_sel, framer_bypass, aligned_frame_pulse, signal_valid, irq;
  logic [8:0]  run_len;
  note_s       notes[$];
  note_s       n;
  int          fails, checks_done, cycles;

  rx_line_lock_monitor #(.ADDR_W(12)) i_dut (
    .clk_sys(clk_sys), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_serial_data(rx_serial_data), .signal_detect_in(signal_detect_in),
    .line_iface_select(line_iface_select), .par_frame_pulse_in(par_frame_pulse_in),
    .data_freq_unlock(data_freq_unlock), .ref_unlock_in(ref_unlock_in),
    .lock_to_data_in(lock_to_data_in), .recovery_mode_sel(recovery_mode_sel),
    .framer_bypass(framer_bypass), .aligned_frame_pulse(aligned_frame_pulse),
    .signal_valid(signal_valid), .irq(irq)
  );

  optical_rx_model i_optics (
    .clk_sys(clk_sys), .power_ok(power_ok), .run_go(run_go), .run_len(run_len),
    .rx_serial_data(rx_serial_data), .signal_detect_in(signal_detect_in)
  );

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic idle(input int cnt);
    repeat (cnt) @(posedge clk_sys);
  endtask : idle

  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    // Waits on the slave's answer; the cycle ceiling cuts a hang short
    while (pready !== 1'b1) @(posedge clk_sys);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d, 4'hF);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp,
                    input logic [31:0] msk = 32'h0000_00FF, input logic err = 1'b0);
    notes.push_back('{err, msk, exp});
    // Reads carry no byte strobes
    apb(a, 1'b0, 32'h0000_0000, 4'h0);
  endtask : rd

  task automatic start_run(input logic [8:0] len);
    @(posedge clk_sys);
    run_len <= len;
    run_go  <= 1'b1;
    @(posedge clk_sys);
    run_go  <= 1'b0;
  endtask : start_run

  ////////////////////////////////////////////////////////////////////////////////
  // Scoreboard: each completed read is matched against the oldest note
  always @(posedge clk_sys) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      if (notes.size() == 0) begin
        fails++;
        $display("wrong value read count expected none seen one");
      end else begin
        n = notes.pop_front();
        check("prdata", prdata & n.msk, n.dat & n.msk);
        check("pslverr", 32'(pslverr), 32'(n.err));
      end
    end
  end

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      fails++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {resetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {line_iface_select, par_frame_pulse_in, data_freq_unlock} = '0;
    {ref_unlock_in, lock_to_data_in, run_go, run_len} = '0;
    power_ok = 1'b1;
    fails = 0;
    checks_done = 0;
    cycles = 0;
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    v = $urandom(99);
    idle(4);
    rd(A_CFG, 8'h00, 32'h0000_00F0);
    rd(A_STS, 8'h00);
    rd(A_REC, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 2; i++) begin
      v = $urandom;
      v[5] = i[0];
      wr(A_REC, v);
      rd(A_REC, v & 32'h0000_00F3);
      check("recovery_mode_sel", 32'(recovery_mode_sel), 32'(i));
    end
    // Byte lane 0 not strobed, so the write must leave the register alone
    apb(A_REC, 1'b1, ~v, 4'hE);
    rd(A_REC, v & 32'h0000_00F3);
    wr(A_STS, 8'hFF);
    rd(A_STS, 8'h07);
    check("irq idle", 32'(irq), 0);
    wr(A_BAD, 8'hFF);
    rd(A_BAD, 8'h00, 32'hFFFF_FFFF, 1'b1);
    $display("test registers done");
    wr(A_STS, 8'h04);
    wr(A_CFG, 8'h80);
    idle(4);
    check("signal_valid inverted", 32'(signal_valid), 0);
    check("irq loss", 32'(irq), 1);
    rd(A_STS, 8'h44);
    rd(A_CFG, 8'h84);
    rd(A_CFG, 8'h80);
    check("irq cleared", 32'(irq), 0);
    power_ok <= 1'b0;
    idle(4);
    check("signal_valid low pin", 32'(signal_valid), 1);
    rd(A_STS, 8'h04);
    wr(A_CFG, 8'h00);
    power_ok <= 1'b1;
    idle(4);
    // The two steps above take effect on the same edge, so signal detect stays valid; drop any flag still set
    rd(A_CFG, 8'h00, 32'h0000_0000);
    $display("test invert done");
    start_run(9'd96);
    idle(100);
    rd(A_CFG, 8'h00);
    rd(A_STS, 8'h04);
    for (int s = 0; s < 2; s++) begin
      wr(A_CFG, s ? 8'h20 : 8'h00);
      start_run(9'd200);
      idle(110);
      rd(A_STS, 8'h54);
      idle(100);
      check("irq run", 32'(irq), 32'(s == 0));
      rd(A_CFG, s ? 8'h21 : 8'h05);
    end
    wr(A_CFG, 8'h00);
    $display("test run done");
    for (int e = 1; e >= 0; e--) begin
      wr(A_STS, 8'(e));
      data_freq_unlock <= 1'b1;
      idle(4);
      check("irq data", 32'(irq), 32'(e));
      rd(A_STS, 8'h10 | 8'(e));
      rd(A_CFG, 8'h01);
      data_freq_unlock <= 1'b0;
      idle(4);
      rd(A_CFG, 8'h00);
    end
    $display("test data done");
    // Leave data and loss flags set, then raise both events at the access edge of a clearing read
    data_freq_unlock <= 1'b1;
    power_ok         <= 1'b0;
    idle(3);
    data_freq_unlock <= 1'b0;
    power_ok         <= 1'b1;
    idle(3);
    fork
      rd(A_CFG, 8'h05);
      begin
        idle(2);
        data_freq_unlock <= 1'b1;
        power_ok         <= 1'b0;
      end
    join
    rd(A_CFG, 8'h05);
    data_freq_unlock <= 1'b0;
    power_ok         <= 1'b1;
    idle(3);
    rd(A_CFG, 8'h00);
    $display("test coincide done");
    for (int e = 1; e >= 0; e--) begin
      wr(A_STS, 8'(e << 1));
      for (int l = 1; l >= 0; l--) begin
        ref_unlock_in <= l[0];
        idle(4);
        check("irq ref", 32'(irq), 32'(e));
        rd(A_STS, 8'(l << 5) | 8'(e << 1));
        rd(A_CFG, 8'h02);
      end
    end
    $display("test ref done");
    for (int l = 1; l >= 0; l--) begin
      lock_to_data_in <= l[0];
      idle(3);
      rd(A_STS, 8'(l << 7));
    end
    $display("test lock done");
    wr(A_CFG, 8'h40);
    for (int s = 0; s < 2; s++) begin
      line_iface_select  <= s[0];
      par_frame_pulse_in <= 1'b1;
      idle(3);
      check("framer_bypass", 32'(framer_bypass), 32'(s));
      check("aligned pulse", 32'(aligned_frame_pulse), 32'(s));
      par_frame_pulse_in <= 1'b0;
      idle(3);
      check("aligned idle", 32'(aligned_frame_pulse), 0);
    end
    wr(A_CFG, 8'h00);
    idle(3);
    check("framer_bypass off", 32'(framer_bypass), 0);
    $display("test frame done");
    tally_and_finish();
  end
endmodule : rx_line_lock_monitor_tb_top

// File: rtl/event_flag.sv
// Sticky event flag with a clear that never swallows a coincident event.
// Assumes set and clear are single-cycle terms of clk_sys.
`timescale 1ns/1ps
module event_flag (
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic set_evt,
  input  wire logic clear,
  output logic      flag
);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      flag <= 1'b0;
    end else begin
      // Set wins over clear
      flag <= set_evt | (flag & ~clear);
    end
  end

endmodule : event_flag

// File: rtl/run_length_detector.sv
// Counts identical consecutive receive bits and flags a run longer than the limit.
// Assumes one received bit is presented on every clk_sys edge.
`timescale 1ns/1ps
`include "rx_line_cfg.svh"
module run_length_detector #(
  parameter int RUN_W = `RXL_RUN_W,
  parameter int LIMIT = `RXL_RUN_LIMIT
) (
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic rx_bit,
  output logic      long_run
);

  generate
    if (LIMIT < 1 || LIMIT >= (2 ** RUN_W) - 1) begin : g_bad_limit
      $error("run_length_detector: LIMIT does not fit the counter");
    end
  endgenerate

  localparam logic [RUN_W-1:0] RUN_MAX = '1;
  localparam logic [RUN_W-1:0] RUN_LIM = RUN_W'(LIMIT);

  logic             prev_bit;
  logic [RUN_W-1:0] run_len;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prev_bit <= 1'b0;
      run_len  <= '0;
    end else begin
      prev_bit <= rx_bit;
      // Saturate so a dead line keeps reporting loss
      if (rx_bit != prev_bit || run_len == '0) begin
        run_len <= RUN_W'(1);
      end else if (run_len != RUN_MAX) begin
        run_len <= run_len + RUN_W'(1);
      end
    end
  end

  // More than LIMIT identical bits in a row
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      long_run <= 1'b0;
    end else begin
      long_run <= (rx_bit == prev_bit && run_len >= RUN_LIM);
    end
  end

endmodule : run_length_detector

// File: rtl/rx_line_lock_monitor.sv
// Receive line monitor: loss of transition, lock status, interrupt flags, APB registers.
// Assumes all inputs synchronous to clk_sys, one serial bit per clock, zero-wait APB master.
`timescale 1ns/1ps
`include "rx_line_cfg.svh"
module rx_line_lock_monitor
  import rx_line_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              rx_serial_data,
  input  wire logic              signal_detect_in,
  input  wire logic              line_iface_select,
  input  wire logic              par_frame_pulse_in,
  input  wire logic              data_freq_unlock,
  input  wire logic              ref_unlock_in,
  input  wire logic              lock_to_data_in,
  output logic                   recovery_mode_sel,
  output logic                   framer_bypass,
  output logic                   aligned_frame_pulse,
  output logic                   signal_valid,
  output logic                   irq
);

  generate
    if (ADDR_W < 12) begin : g_bad_addr
      $error("rx_line_lock_monitor: ADDR_W too narrow for the register map");
    end
  endgenerate

  localparam logic [ADDR_W-1:0] ADDR_CONFIG   = ADDR_W'(`RXL_IDX_CONFIG * 4);
  localparam logic [ADDR_W-1:0] ADDR_STATUS   = ADDR_W'(`RXL_IDX_STATUS * 4);
  localparam logic [ADDR_W-1:0] ADDR_RECOVERY = ADDR_W'(`RXL_IDX_RECOVERY * 4);

  ////////////////////////////////////////////////////////////////////////////////
  // Register storage

  reg_byte_t    config_rw;
  reg_byte_t    status_rw;
  reg_byte_t    recovery_rw;
  lock_events_s flags;
  lock_events_s int_en;
  lock_events_s state;
  lock_events_s events;
  lock_events_s clr;
  lock_events_s rd_flags;
  logic         lock_src;
  logic         lot_declared_q;

  logic sig_detect_invert;
  logic par_frame_pulse_en;
  logic transition_detector_select;

  assign sig_detect_invert          = config_rw[`RXL_POS_SIG_INV];
  assign par_frame_pulse_en         = config_rw[`RXL_POS_PFP_EN];
  assign transition_detector_select = config_rw[`RXL_POS_DET_SEL];
  assign int_en.no_transition       = status_rw[`RXL_POS_LOT_EN];
  assign int_en.ref_unlock          = status_rw[`RXL_POS_REF_EN];
  assign int_en.data_unlock         = status_rw[`RXL_POS_DATA_EN];

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, read data captured in the setup cycle

  logic setup_phase;
  logic access_phase;
  logic hit_config;
  logic hit_status;
  logic hit_recovery;
  logic hit_any;
  logic wr_lane0;
  logic rd_config;

  assign setup_phase  = psel & ~penable;
  assign access_phase = psel & penable;
  assign hit_config   = (paddr == ADDR_CONFIG);
  assign hit_status   = (paddr == ADDR_STATUS);
  assign hit_recovery = (paddr == ADDR_RECOVERY);
  assign hit_any      = hit_config | hit_status | hit_recovery;
  assign wr_lane0     = access_phase & pwrite & pstrb[0];
  assign rd_config    = access_phase & ~pwrite & hit_config;

  assign pready  = 1'b1;
  assign pslverr = access_phase & ~hit_any;

  reg_byte_t next_rd_byte;

  always_comb begin
    next_rd_byte = 8'h00;
    if (hit_config) begin
      next_rd_byte = config_rw;
      next_rd_byte[`RXL_POS_LOT_FLAG]  = flags.no_transition;
      next_rd_byte[`RXL_POS_REF_FLAG]  = flags.ref_unlock;
      next_rd_byte[`RXL_POS_DATA_FLAG] = flags.data_unlock;
    end else if (hit_status) begin
      next_rd_byte = status_rw;
      next_rd_byte[`RXL_POS_LOCK_SRC]   = lock_src;
      next_rd_byte[`RXL_POS_LOT_STATE]  = state.no_transition;
      next_rd_byte[`RXL_POS_REF_STATE]  = state.ref_unlock;
      next_rd_byte[`RXL_POS_DATA_STATE] = state.data_unlock;
    end else if (hit_recovery) begin
      next_rd_byte = recovery_rw;
    end
  end

  // Capturing the flags with the data lets the clear drop only what software saw
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prdata   <= 32'h0000_0000;
      rd_flags <= '0;
    end else if (setup_phase && !pwrite) begin
      prdata   <= {24'h00_0000, next_rd_byte};
      rd_flags <= hit_config ? flags : '0;
    end
  end

  // Read-to-clear of the flag register
  assign clr = rd_config ? rd_flags : '0;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      config_rw <= `RXL_CONFIG_RST;
    end else if (wr_lane0 && hit_config) begin
      config_rw <= pwdata[7:0] & `RXL_CONFIG_WMASK;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      status_rw <= `RXL_STATUS_RST;
    end else if (wr_lane0 && hit_status) begin
      status_rw <= pwdata[7:0] & `RXL_STATUS_WMASK;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      recovery_rw <= `RXL_RECOVERY_RST;
    end else if (wr_lane0 && hit_recovery) begin
      recovery_rw <= pwdata[7:0] & `RXL_RECOVERY_WMASK;
    end
  end

  // LAN at zero, WAN at one
  assign recovery_mode_sel = recovery_rw[`RXL_POS_RECOV_MODE];

  ////////////////////////////////////////////////////////////////////////////////
  // Line condition monitoring

  logic sd_eff;
  logic long_run;
  logic lot_raw;
  logic lot_declared;
  logic next_data_unlock;

  assign sd_eff = signal_detect_in ^ sig_detect_invert;

  run_length_detector #(
    .RUN_W (`RXL_RUN_W),
    .LIMIT (`RXL_RUN_LIMIT)
  ) u_run (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .rx_bit   (rx_serial_data),
    .long_run (long_run)
  );

  // Status view ignores the detector select; only event declaration honours it
  assign lot_raw          = ~sd_eff | long_run;
  assign lot_declared     = ~sd_eff | (~transition_detector_select & long_run);
  assign next_data_unlock = data_freq_unlock | long_run;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state          <= '0;
      lot_declared_q <= 1'b0;
      lock_src       <= 1'b0;
      signal_valid   <= 1'b0;
    end else begin
      state.no_transition <= lot_raw;
      state.ref_unlock    <= ref_unlock_in;
      state.data_unlock   <= next_data_unlock;
      lot_declared_q      <= lot_declared;
      lock_src            <= lock_to_data_in;
      signal_valid        <= sd_eff;
    end
  end

  assign events.data_unlock   = next_data_unlock & ~state.data_unlock;
  assign events.ref_unlock    = ref_unlock_in ^ state.ref_unlock;
  assign events.no_transition = lot_declared & ~lot_declared_q;

  event_flag u_flag_data (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .set_evt (events.data_unlock),
    .clear   (clr.data_unlock),
    .flag    (flags.data_unlock)
  );

  event_flag u_flag_ref (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .set_evt (events.ref_unlock),
    .clear   (clr.ref_unlock),
    .flag    (flags.ref_unlock)
  );

  event_flag u_flag_lot (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .set_evt (events.no_transition),
    .clear   (clr.no_transition),
    .flag    (flags.no_transition)
  );

  // Flags latch regardless of enables; enables only gate the pin
  assign irq = |(flags & int_en);

  ////////////////////////////////////////////////////////////////////////////////
  // Parallel framing control

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      framer_bypass       <= 1'b0;
      aligned_frame_pulse <= 1'b0;
    end else begin
      // Serial interface forces the framer on whatever the enable says
      framer_bypass       <= line_iface_select & par_frame_pulse_en;
      aligned_frame_pulse <= line_iface_select & par_frame_pulse_en & par_frame_pulse_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  chk_data_flag_set: assert property (
    events.data_unlock |=> flags.data_unlock)
    else $error("data unlock event did not set its flag");

  chk_data_flag_clear: assert property (
    rd_config && rd_flags.data_unlock && !events.data_unlock |=> !flags.data_unlock)
    else $error("data unlock flag not cleared by read");

  chk_ref_both_edges: assert property (
    $changed(state.ref_unlock) |-> flags.ref_unlock)
    else $error("reference state change did not set its flag");

  chk_lot_flag_set: assert property (
    $rose(lot_declared_q) |-> flags.no_transition)
    else $error("transition loss did not set its flag");

  chk_lot_select: assert property (
    transition_detector_select && sd_eff |=> !lot_declared_q)
    else $error("long run declared loss with detector deselected");

  chk_lot_run: assert property (
    !transition_detector_select && long_run |=> lot_declared_q)
    else $error("long run not declared as loss");

  chk_lot_state: assert property (
    (long_run || !sd_eff) |=> state.no_transition)
    else $error("loss status low during loss condition");

  chk_sd_invert: assert property (
    sig_detect_invert && !signal_detect_in |=> signal_valid)
    else $error("inverted signal detect not honoured");

  chk_serial_no_bypass: assert property (
    !line_iface_select |=> !framer_bypass && !aligned_frame_pulse)
    else $error("framer bypassed in serial mode");

  chk_frame_pulse: assert property (
    line_iface_select && par_frame_pulse_en && par_frame_pulse_in |=> aligned_frame_pulse)
    else $error("frame pulse not passed in parallel mode");

  chk_irq_gate: assert property (
    flags.ref_unlock && !int_en.ref_unlock && !(flags.data_unlock && int_en.data_unlock)
      && !(flags.no_transition && int_en.no_transition) |-> !irq)
    else $error("interrupt raised by a disabled flag");

  chk_irq_raise: assert property (
    events.data_unlock && int_en.data_unlock && !(wr_lane0 && hit_status) |=> irq)
    else $error("enabled data unlock event raised no interrupt");

  chk_data_unlock: assert property (
    long_run |=> state.data_unlock)
    else $error("idle line not reported as data unlock");

  chk_event_kept: assert property (
    events.no_transition && clr.no_transition |=> flags.no_transition)
    else $error("event lost during clearing read");

  chk_data_kept: assert property (
    events.data_unlock && clr.data_unlock |=> flags.data_unlock)
    else $error("data unlock event lost during clearing read");

  chk_lot_flag_clear: assert property (
    rd_config && rd_flags.no_transition && !events.no_transition |=> !flags.no_transition)
    else $error("transition loss flag not cleared by read");

  chk_mode_write: assert property (
    wr_lane0 && hit_recovery |=> recovery_mode_sel == $past(pwdata[`RXL_POS_RECOV_MODE]))
    else $error("recovery mode did not follow the write");

  cov_ref_flag_read: cover property (
    rd_config && rd_flags.ref_unlock);

  cov_lot_irq: cover property (
    events.no_transition && int_en.no_transition ##1 irq);

  cov_set_during_clear: cover property (
    events.data_unlock && rd_config);

  cov_ref_fall: cover property (
    $fell(state.ref_unlock));

endmodule : rx_line_lock_monitor

// File: shared/rx_line_cfg.svh
// Register indices, field positions, reset values and counts of the receive line monitor.
// Assumes inclusion by bare name from files that need these constants.
`ifndef RX_LINE_CFG_SVH
`define RX_LINE_CFG_SVH

// Register indices; the byte address on the bus is four times the index
`define RXL_IDX_CONFIG        12'h05C
`define RXL_IDX_STATUS        12'h05D
`define RXL_IDX_RECOVERY      12'h05E

// Configuration / flag register fields
`define RXL_POS_SIG_INV       7
`define RXL_POS_PFP_EN        6
`define RXL_POS_DET_SEL       5
`define RXL_POS_CFG_RSVD      4
`define RXL_POS_LOT_FLAG      2
`define RXL_POS_REF_FLAG      1
`define RXL_POS_DATA_FLAG     0

// Status / enable register fields
`define RXL_POS_LOCK_SRC      7
`define RXL_POS_LOT_STATE     6
`define RXL_POS_REF_STATE     5
`define RXL_POS_DATA_STATE    4
`define RXL_POS_LOT_EN        2
`define RXL_POS_REF_EN        1
`define RXL_POS_DATA_EN       0

// Clock recovery control fields
`define RXL_POS_RECOV_MODE    5

// Writable bits of each register and their reset values
`define RXL_CONFIG_WMASK      8'hF0
`define RXL_STATUS_WMASK      8'h07
`define RXL_RECOVERY_WMASK    8'hF3
`define RXL_CONFIG_RST        8'h00
`define RXL_STATUS_RST        8'h00
`define RXL_RECOVERY_RST      8'h00

// Run of identical bits beyond which transitions count as lost
`define RXL_RUN_LIMIT         96
`define RXL_RUN_W             7

`endif

// File: shared/rx_line_pkg.sv
// Types shared by the receive line monitor modules.
// Assumes the constants header is compiled alongside.
package rx_line_pkg;

  // One bit per monitored condition, in flag-register order
  typedef struct packed {
    logic no_transition;
    logic ref_unlock;
    logic data_unlock;
  } lock_events_s;

  typedef logic [7:0] reg_byte_t;

endpackage : rx_line_pkg
